// file: design/blo_ctrl_regs.vh
`ifndef BLO_CTRL_REGS_VH
`define BLO_CTRL_REGS_VH
// Register byte offsets
`define BLO_CTRL      8'h00
`define BLO_FREQIN    8'h04
`define BLO_FREQOFS   8'h08
`define BLO_REFLVL    8'h0C
`define BLO_VREF      8'h10
`define BLO_VMAX      8'h14
`define BLO_VMIN      8'h18
`define BLO_SLOPE     8'h1C
`define BLO_GAIN      8'h20
`define BLO_STATUS    8'h24
`define BLO_ALARM     8'h28
`define BLO_DFREQ     8'h2C
`define BLO_DLVL      8'h30
`define BLO_VOUT      8'h34
`define BLO_IFGAIN    8'h38
// CTRL fields
`define BLO_C_TBW     1:0
`define BLO_C_ACQ     4:2
`define BLO_C_TRK     7:5
`define BLO_C_MAN     8
`define BLO_C_VBW     11:9
`define BLO_C_PWR     12
`define BLO_C_CAP     13
// SLOPE register fields
`define BLO_S_IDX     3:0
`define BLO_S_HOLD    7:4
// Alarm bits
`define BLO_A_RF      0
`define BLO_A_IF      1
`define BLO_A_REJ     2
// Reset values
`define BLO_CTRL_RST  32'h0000_0024
`define BLO_REF_RST   16'hFC18
`define BLO_VREF_RST  16'h0000
`define BLO_VMAX_RST  16'h03E8
`define BLO_VMIN_RST  16'hFC18
`define BLO_SLOPE_RST 8'h07
// Limits (0.1 dB, 10 mV units)
`define BLO_REF_HI    16'hFF9C
`define BLO_REF_LO    16'hFBB4
`define BLO_V_HI      16'h03E8
`define BLO_V_LO      16'hFC18
`define BLO_RFLOW_TH  16'hFDA8
`define BLO_RFG_MAX   8'hC8
`define BLO_IFSUM_MAX 9'h12C
// Timing
`define BLO_CLK_HZ    50000000
`define BLO_SEC_CYC   (`BLO_CLK_HZ * 1)
`endif

// file: design/blo_ctrl.v
// How it works
// RL1 - Tuner bandwidth only 7.5, 150 or 340 kHz; other codes rejected.
// RL2 - Acquisition range only 0,10,20,50,100,200,500 or 700 kHz steps.
// RL3 - Acquisition range must exceed tuner bandwidth, else write rejected.
// RL4 - Carrier search limited to acquisition range around input plus offset.
// RL5 - Lock kept inside tracking range around input frequency, dropped outside.
// RL6 - Tracking range one of seven steps and must exceed tuner bandwidth.
// RL7 - Delta frequency is measured carrier minus tuned centre.
// RL8 - RF gain too high raises over-range flag and logs alarm.
// RL9 - Input power low flag while RF power below -60 dBm.
// RL10 - Automatic mode takes loop IF gain, manual mode the programmed gain.
// RL11 - Manual mode flags IF over-range on excessive summed gains, logs alarm.
// RL12 - Signal strength averaged at one of seven video bandwidths.
// RL13 - Reference level accepted from -10 to -110 dBm in 0.1 dB.
// RL14 - Capture command copies measured strength into reference level.
// RL15 - Delta level is signal strength minus reference level.
// RL16 - Output is reference volts plus delta over slope, clamped to limits.
// RL17 - Reference voltage -10..+10 V in 10 mV, between min and max.
// RL18 - Max and min limits -10..+10 V, bracketing the reference voltage.
// RL19 - Slope one of fourteen signed steps; sign sets output direction.
// RL20 - On lock loss output frozen for holdtime, then driven to a limit.
// RL21 - Holdtime choices 0 to 600 seconds in eleven steps.
// RL22 - Power mode selects peak or total power as signal strength.
// RL23 - After holdtime positive slope gives minimum, negative gives maximum.
// RL24 - Flags follow their conditions; logged alarms stay until cleared.
`timescale 1ns/1ps
`include "blo_ctrl_regs.vh"
module blo_ctrl #(
  parameter SEC_CYC = `BLO_SEC_CYC
) (
  // System
  input  wire               clk_sys,
  input  wire               rst_n,
  // Wishbone slave
  input  wire               wb_cyc_i,
  input  wire               wb_stb_i,
  input  wire               wb_we_i,
  input  wire [7:0]         wb_adr_i,
  input  wire [3:0]         wb_sel_i,
  input  wire [31:0]        wb_dat_i,
  output reg  [31:0]        wb_dat_o,
  output reg                wb_ack_o,
  // Measurement path
  input  wire               measStb,
  input  wire signed [15:0] peakPower,
  input  wire signed [15:0] totalPower,
  input  wire signed [15:0] rfPower,
  input  wire               carrierValid,
  input  wire [23:0]        carrierFreq,
  input  wire [7:0]         agcGain,
  // Tuner and gain controls
  output reg  [23:0]        tuneFreq,
  output reg  [12:0]        acqRangeKhz,
  output reg  [1:0]         tunerBwSel,
  output reg  [2:0]         videoBwSel,
  output reg  [7:0]         rfGainSet,
  output reg  [7:0]         ifGainSet,
  // Status and output converter
  output reg                carrierLock,
  output reg                input_power_low_flag,
  output reg                rfOverRange,
  output reg                ifOverRange,
  output reg signed [15:0]  voutLevel
);

  localparam LK_SEARCH = 2'd0;
  localparam LK_LOCKED = 2'd1;
  localparam LK_HOLD   = 2'd2;
  localparam LK_LIMIT  = 2'd3;

  reg        [31:0] ctrl_q;
  reg        [23:0] freqIn_q;
  reg signed [23:0] freqOfs_q;
  reg signed [15:0] refLvl_q;
  reg signed [15:0] vRef_q;
  reg signed [15:0] vMax_q;
  reg signed [15:0] vMin_q;
  reg        [7:0]  slope_q;
  reg        [15:0] gain_q;
  reg        [2:0]  alarm_q;
  reg        [1:0]  lkState_q;
  reg        [25:0] secCnt_q;
  reg        [9:0]  holdCnt_q;
  reg signed [23:0] avgAcc_q;
  reg               rfOvPrev_q;
  reg               ifOvPrev_q;

  // Range tables, widths in 0.1 kHz; holdtime table in seconds
  function [13:0] bwTenths;
    input [1:0] s;
    begin
      case (s)
        2'd0:    bwTenths = 14'd75;
        2'd1:    bwTenths = 14'd1500;
        default: bwTenths = 14'd3400;
      endcase
    end
  endfunction

  function [13:0] acqTenths;
    input [2:0] s;
    begin
      case (s)
        3'd0:    acqTenths = 14'd0;
        3'd1:    acqTenths = 14'd100;
        3'd2:    acqTenths = 14'd200;
        3'd3:    acqTenths = 14'd500;
        3'd4:    acqTenths = 14'd1000;
        3'd5:    acqTenths = 14'd2000;
        3'd6:    acqTenths = 14'd5000;
        default: acqTenths = 14'd7000;
      endcase
    end
  endfunction

  // Tracking index 0..6 maps onto acquisition steps 1..7
  function [13:0] trkTenths;
    input [2:0] s;
    begin
      trkTenths = acqTenths(s + 3'd1);
    end
  endfunction

  function [9:0] holdSec;
    input [3:0] s;
    begin
      case (s)
        4'd0:    holdSec = 10'd0;
        4'd1:    holdSec = 10'd1;
        4'd2:    holdSec = 10'd2;
        4'd3:    holdSec = 10'd5;
        4'd4:    holdSec = 10'd10;
        4'd5:    holdSec = 10'd15;
        4'd6:    holdSec = 10'd30;
        4'd7:    holdSec = 10'd60;
        4'd8:    holdSec = 10'd120;
        4'd9:    holdSec = 10'd300;
        default: holdSec = 10'd600;
      endcase
    end
  endfunction

  // Settings and checks
  wire        [1:0] tbw     = ctrl_q[`BLO_C_TBW];
  wire        [2:0] acq     = ctrl_q[`BLO_C_ACQ];
  wire        [2:0] trk     = ctrl_q[`BLO_C_TRK];
  wire              manMode = ctrl_q[`BLO_C_MAN];
  wire        [3:0] slpIdx  = slope_q[`BLO_S_IDX];
  wire              slpNeg  = slpIdx < 4'd7;
  wire              wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire              wbWr    = wbReq & wb_we_i & (wb_sel_i == 4'hF);
  wire        [1:0] nTbw    = wb_dat_i[`BLO_C_TBW];
  wire        [2:0] nAcq    = wb_dat_i[`BLO_C_ACQ];
  wire        [2:0] nTrk    = wb_dat_i[`BLO_C_TRK];
  wire        [2:0] nVbw    = wb_dat_i[`BLO_C_VBW];
  wire signed [15:0] nV     = wb_dat_i[15:0];
  wire ctrlOk = (nTbw != 2'd3) && (nTrk != 3'd7) && (nVbw != 3'd7) &&         // RL1 RL12
                (acqTenths(nAcq) > bwTenths(nTbw)) &&                        // RL2 RL3
                (trkTenths(nTrk) > bwTenths(nTbw));                          // RL6
  wire refOk  = (nV <= $signed(`BLO_REF_HI)) && (nV >= $signed(`BLO_REF_LO)); // RL13
  wire vInRng = (nV <= $signed(`BLO_V_HI)) && (nV >= $signed(`BLO_V_LO));
  wire vrefOk = vInRng && (nV <= vMax_q) && (nV >= vMin_q);                   // RL17
  wire vmaxOk = vInRng && (nV >= vRef_q);                                     // RL18
  wire vminOk = vInRng && (nV <= vRef_q);                                     // RL18
  wire slpOk  = (wb_dat_i[3:0] < 4'd14) && (wb_dat_i[7:4] < 4'd11);           // RL19 RL21

  // Frequency windows
  wire signed [25:0] srchCtr = $signed({2'b00, freqIn_q}) +
                               $signed({{2{freqOfs_q[23]}}, freqOfs_q});
  wire signed [25:0] acqErr  = $signed({2'b00, carrierFreq}) - srchCtr;
  wire signed [25:0] trkErr  = $signed({2'b00, carrierFreq}) - $signed({2'b00, freqIn_q});
  wire        [25:0] acqAbs  = acqErr[25] ? -acqErr : acqErr;
  wire        [25:0] trkAbs  = trkErr[25] ? -trkErr : trkErr;
  // Window half widths in kHz
  wire        [13:0] acqDiv  = acqTenths(acq) / 14'd10;
  wire        [13:0] trkDiv  = trkTenths(trk) / 14'd10;
  wire        [12:0] acqKhz  = acqDiv[12:0];
  wire        [12:0] trkKhz  = trkDiv[12:0];
  wire               inAcq   = carrierValid && (acqAbs <= {13'd0, acqKhz});   // RL4
  wire               inTrk   = carrierValid && (trkAbs <= {13'd0, trkKhz});   // RL5
  wire signed [25:0] dFreq   = $signed({2'b00, carrierFreq}) - srchCtr;       // RL7

  // Levels and output voltage
  wire signed [15:0] rawSig  = ctrl_q[`BLO_C_PWR] ? totalPower : peakPower;   // RL22
  wire signed [15:0] sigAvg  = avgAcc_q[23:8];
  wire signed [16:0] dLvl    = sigAvg - refLvl_q;                             // RL15
  wire        [3:0]  vShift  = 4'd8 - {1'b0, ctrl_q[`BLO_C_VBW]};
  wire signed [23:0] avgStep = ($signed({rawSig, 8'h00}) - avgAcc_q) >>> vShift; // RL12
  wire        [3:0]  slpMag  = slpNeg ? (4'd6 - slpIdx) : (slpIdx - 4'd7);
  // Twenty 10 mV steps per 0.1 dB at 0.5 dB/V
  wire signed [21:0] dScaled = $signed({{5{dLvl[16]}}, dLvl}) * 22'sd20;
  reg  signed [21:0] dOverS;
  reg  signed [22:0] vRaw;
  reg  signed [15:0] vClamp;
  reg  signed [15:0] refCap;
  wire               rfOver  = rfGainSet > `BLO_RFG_MAX;                      // RL8
  wire        [8:0]  ifSum   = {1'b0, gain_q[7:0]} + {1'b0, gain_q[15:8]};
  wire               ifOver  = manMode && (ifSum > `BLO_IFSUM_MAX);          // RL11

  // Slope held in half dB/V steps: 0.5,1,2,4,6,8,10
  always @* begin
    case (slpMag)
      4'd0:    dOverS = dScaled;
      4'd1:    dOverS = dScaled / 22'sd2;
      4'd2:    dOverS = dScaled / 22'sd4;
      4'd3:    dOverS = dScaled / 22'sd8;
      4'd4:    dOverS = dScaled / 22'sd12;
      4'd5:    dOverS = dScaled / 22'sd16;
      default: dOverS = dScaled / 22'sd20;
    endcase
    if (slpNeg)
      dOverS = -dOverS;                                                       // RL19
    vRaw = {{7{vRef_q[15]}}, vRef_q} + {dOverS[21], dOverS};                  // RL16
    if (vRaw > $signed({{7{vMax_q[15]}}, vMax_q}))
      vClamp = vMax_q;
    else if (vRaw < $signed({{7{vMin_q[15]}}, vMin_q}))
      vClamp = vMin_q;
    else
      vClamp = vRaw[15:0];
    if (sigAvg > $signed(`BLO_REF_HI))
      refCap = `BLO_REF_HI;
    else if (sigAvg < $signed(`BLO_REF_LO))
      refCap = `BLO_REF_LO;
    else
      refCap = sigAvg;
  end

  // Register file and bus
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q    <= `BLO_CTRL_RST;
      freqIn_q  <= 24'h000000;
      freqOfs_q <= 24'h000000;
      refLvl_q  <= `BLO_REF_RST;
      vRef_q    <= `BLO_VREF_RST;
      vMax_q    <= `BLO_VMAX_RST;
      vMin_q    <= `BLO_VMIN_RST;
      slope_q   <= `BLO_SLOPE_RST;
      gain_q    <= 16'h0000;
      alarm_q   <= 3'b000;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq;
      // A rejected setting keeps the previous value
      if (wbWr) begin
        case (wb_adr_i)
          `BLO_CTRL:
            if (ctrlOk)
              ctrl_q <= {19'h00000, wb_dat_i[12:0]};
          `BLO_FREQIN:  freqIn_q  <= wb_dat_i[23:0];
          `BLO_FREQOFS: freqOfs_q <= wb_dat_i[23:0];
          `BLO_REFLVL:
            if (refOk)
              refLvl_q <= nV;                                                 // RL13
          `BLO_VREF:
            if (vrefOk)
              vRef_q <= nV;                                                   // RL17
          `BLO_VMAX:
            if (vmaxOk)
              vMax_q <= nV;                                                   // RL18
          `BLO_VMIN:
            if (vminOk)
              vMin_q <= nV;                                                   // RL18
          `BLO_SLOPE:
            if (slpOk)
              slope_q <= wb_dat_i[7:0];
          `BLO_GAIN:    gain_q <= wb_dat_i[15:0];
          default: ;
        endcase
        // Capture needs a valid control word to go with it
        if (wb_adr_i == `BLO_CTRL && ctrlOk && wb_dat_i[`BLO_C_CAP])
          refLvl_q <= refCap;                                                 // RL14
      end
      // Alarm log: write one to clear, a new event wins over the clear
      alarm_q <= (wbWr && wb_adr_i == `BLO_ALARM) ? (alarm_q & ~wb_dat_i[2:0]) : alarm_q;
      if (rfOver && !rfOvPrev_q)
        alarm_q[`BLO_A_RF] <= 1'b1;                                           // RL8 RL24
      if (ifOver && !ifOvPrev_q)
        alarm_q[`BLO_A_IF] <= 1'b1;                                           // RL11 RL24
      if (wbWr && !((wb_adr_i == `BLO_CTRL && ctrlOk) ||
                    (wb_adr_i == `BLO_REFLVL && refOk) ||
                    (wb_adr_i == `BLO_VREF && vrefOk) ||
                    (wb_adr_i == `BLO_VMAX && vmaxOk) ||
                    (wb_adr_i == `BLO_VMIN && vminOk) ||
                    (wb_adr_i == `BLO_SLOPE && slpOk) ||
                    (wb_adr_i == `BLO_FREQIN) || (wb_adr_i == `BLO_FREQOFS) ||
                    (wb_adr_i == `BLO_GAIN) || (wb_adr_i == `BLO_ALARM)))
        alarm_q[`BLO_A_REJ] <= 1'b1;                                          // RL3
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `BLO_CTRL:    wb_dat_o <= ctrl_q;
          `BLO_FREQIN:  wb_dat_o <= {8'h00, freqIn_q};
          `BLO_FREQOFS: wb_dat_o <= {8'h00, freqOfs_q};
          `BLO_REFLVL:  wb_dat_o <= {16'h0000, refLvl_q};
          `BLO_VREF:    wb_dat_o <= {16'h0000, vRef_q};
          `BLO_VMAX:    wb_dat_o <= {16'h0000, vMax_q};
          `BLO_VMIN:    wb_dat_o <= {16'h0000, vMin_q};
          `BLO_SLOPE:   wb_dat_o <= {24'h000000, slope_q};
          `BLO_GAIN:    wb_dat_o <= {16'h0000, gain_q};
          `BLO_STATUS:  wb_dat_o <= {26'h0000000, lkState_q, ifOverRange, rfOverRange,
                                     input_power_low_flag, carrierLock};
          `BLO_ALARM:   wb_dat_o <= {29'h00000000, alarm_q};
          `BLO_DFREQ:   wb_dat_o <= {{6{dFreq[25]}}, dFreq};
          `BLO_DLVL:    wb_dat_o <= {{15{dLvl[16]}}, dLvl};
          `BLO_VOUT:    wb_dat_o <= {16'h0000, voutLevel};
          `BLO_IFGAIN:  wb_dat_o <= {24'h000000, ifGainSet};
          default:      wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Lock, holdtime and measurement datapath
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      lkState_q            <= LK_SEARCH;
      secCnt_q             <= 26'd0;
      holdCnt_q            <= 10'd0;
      avgAcc_q             <= 24'h000000;
      rfOvPrev_q           <= 1'b0;
      ifOvPrev_q           <= 1'b0;
      carrierLock          <= 1'b0;
      input_power_low_flag <= 1'b0;
      rfOverRange          <= 1'b0;
      ifOverRange          <= 1'b0;
      voutLevel            <= 16'h0000;
      tuneFreq             <= 24'h000000;
      acqRangeKhz          <= 13'd0;
      tunerBwSel           <= 2'd0;
      videoBwSel           <= 3'd0;
      rfGainSet            <= 8'h00;
      ifGainSet            <= 8'h00;
    end else begin
      rfOvPrev_q           <= rfOver;
      ifOvPrev_q           <= ifOver;
      rfOverRange          <= rfOver;                                         // RL8 RL24
      ifOverRange          <= ifOver;                                         // RL11 RL24
      input_power_low_flag <= rfPower < $signed(`BLO_RFLOW_TH);               // RL9 RL24
      tuneFreq             <= srchCtr[23:0];                                  // RL4
      acqRangeKhz          <= acqKhz;
      tunerBwSel           <= tbw;
      videoBwSel           <= ctrl_q[`BLO_C_VBW];
      rfGainSet            <= gain_q[15:8];
      ifGainSet            <= manMode ? gain_q[7:0] : agcGain;                // RL10
      if (measStb)
        avgAcc_q <= avgAcc_q + avgStep;                                       // RL12
      secCnt_q <= (secCnt_q == SEC_CYC - 1) ? 26'd0 : secCnt_q + 26'd1;
      carrierLock <= (lkState_q == LK_LOCKED);
      case (lkState_q)
        LK_SEARCH: begin
          if (inAcq)
            lkState_q <= LK_LOCKED;                                           // RL4
        end
        LK_LOCKED: begin
          voutLevel <= vClamp;                                                // RL16
          if (!inTrk) begin
            lkState_q <= LK_HOLD;                                             // RL5
            holdCnt_q <= holdSec(slope_q[`BLO_S_HOLD]);                       // RL21
            secCnt_q  <= 26'd0;
          end
        end
        LK_HOLD: begin
          // Reacquisition goes through the acquisition window again
          if (inAcq)
            lkState_q <= LK_LOCKED;
          else if (holdCnt_q == 10'd0)
            lkState_q <= LK_LIMIT;                                            // RL20
          else if (secCnt_q == SEC_CYC - 1)
            holdCnt_q <= holdCnt_q - 10'd1;
        end
        LK_LIMIT: begin
          voutLevel <= slpNeg ? vMax_q : vMin_q;                              // RL23
          if (inAcq)
            lkState_q <= LK_LOCKED;
        end
        default: lkState_q <= LK_SEARCH;
      endcase
    end
  end

endmodule

// file: test/blo_meas_model.sv
`timescale 1ns/1ps
// Behavioural stand-in for the measurement path feeding the control block
module blo_meas_model #(
  parameter [7:0] AGC_GAIN = 8'h40
) (
  // Settings from the bench
  input  wire               clk_sys,
  input  wire               carrierOn,
  input  wire [23:0]        freqSet,
  input  wire signed [15:0] powerSet,
  input  wire signed [15:0] rfSet,
  // Measurement outputs
  output reg                measStb,
  output reg signed [15:0]  peakPower,
  output reg signed [15:0]  totalPower,
  output reg signed [15:0]  rfPower,
  output reg                carrierValid,
  output reg [23:0]         carrierFreq,
  output reg [7:0]          agcGain
);
  reg [1:0] phaseQ;
  initial begin
    phaseQ = 2'h0;
    measStb = 1'b0;
    peakPower = 16'sh0;
    totalPower = 16'sh0;
    rfPower = 16'sh0;
    carrierValid = 1'b0;
    carrierFreq = 24'h0;
    agcGain = 8'h0;
  end
  always @(posedge clk_sys) begin
    phaseQ <= phaseQ + 2'h1;
    measStb <= (phaseQ == 2'h0);
    peakPower <= powerSet;
    // Sidebands add a little to the total figure
    totalPower <= powerSet + 16'sd5;
    rfPower <= rfSet;
    carrierValid <= carrierOn;
    // No carrier: frequency word is meaningless, so keep it moving
    carrierFreq <= carrierOn ? freqSet : ~carrierFreq;
    agcGain <= AGC_GAIN;
  end
endmodule

// file: test/blo_ctrl_checker.sv
`timescale 1ns/1ps
module blo_ctrl_checker (
  // System
  input wire               clk_sys,
  input wire               rst_n,
  // Bus
  input wire               wb_cyc_i,
  input wire               wb_stb_i,
  input wire               wb_ack_o,
  // Observed
  input wire signed [15:0] rfPower,
  input wire               carrierValid,
  input wire [12:0]        acqRangeKhz,
  input wire [1:0]         tunerBwSel,
  input wire [2:0]         videoBwSel,
  input wire [7:0]         rfGainSet,
  input wire [7:0]         ifGainSet,
  input wire               carrierLock,
  input wire               input_power_low_flag,
  input wire               rfOverRange,
  input wire               ifOverRange
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_noCarrier;
    (!carrierValid)[*3];
  endsequence
  property p_ackNext; s_req |=> wb_ack_o; endproperty
  property p_ackOnce; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ackCause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_tbw; tunerBwSel != 2'h3; endproperty
  property p_acq; acqRangeKhz inside {0, 10, 20, 50, 100, 200, 500, 700}; endproperty
  property p_vbw; videoBwSel <= 3'h6; endproperty
  property p_pwrLow; (rfPower < -16'sd600)[*3] |-> input_power_low_flag; endproperty
  property p_pwrOk; (rfPower >= -16'sd600)[*3] |-> !input_power_low_flag; endproperty
  property p_rfOv; (rfGainSet > 8'hC8)[*3] |-> rfOverRange; endproperty
  property p_rfOk; (rfGainSet <= 8'hC8)[*3] |-> !rfOverRange; endproperty
  property p_ifOk;
    ({1'b0, rfGainSet} + {1'b0, ifGainSet} <= 9'h12C)[*3] |-> !ifOverRange;
  endproperty
  property p_lockDrop; s_noCarrier |-> !carrierLock; endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack missing after request");
  a_ackOnce: assert property (p_ackOnce) else $error("ack longer than one cycle");
  a_ackCause: assert property (p_ackCause) else $error("ack without request");
  a_tbw: assert property (p_tbw) else $error("illegal tuner bandwidth");
  a_acq: assert property (p_acq) else $error("illegal acquisition range");
  a_vbw: assert property (p_vbw) else $error("illegal video bandwidth");
  a_pwrLow: assert property (p_pwrLow) else $error("low power not flagged");
  a_pwrOk: assert property (p_pwrOk) else $error("low power flag stuck");
  a_rfOv: assert property (p_rfOv) else $error("rf over-range missing");
  a_rfOk: assert property (p_rfOk) else $error("rf over-range stuck");
  a_ifOk: assert property (p_ifOk) else $error("if over-range without cause");
  a_lockDrop: assert property (p_lockDrop) else $error("lock held without carrier");
endmodule
bind blo_ctrl blo_ctrl_checker chk (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .rfPower, .carrierValid, .acqRangeKhz, .tunerBwSel, .videoBwSel, .rfGainSet, .ifGainSet,
  .carrierLock, .input_power_low_flag, .rfOverRange, .ifOverRange);

// file: test/blo_ctrl_bench.sv
`timescale 1ns/1ps
`include "blo_ctrl_regs.vh"
module blo_ctrl_bench;
  localparam SEC = 10;
  localparam [12:0] ACQ [0:7] = '{0, 10, 20, 50, 100, 200, 500, 700};
  reg               clk_sys;
  reg               rst_n;
  reg               wbCyc;
  reg               wbStb;
  reg               wbWe;
  reg  [7:0]        wbAdr;
  reg  [3:0]        wbSel;
  reg  [31:0]       wbDatW;
  reg               carrierOn;
  reg  [23:0]       freqSet;
  reg signed [15:0] powerSet;
  reg signed [15:0] rfSet;
  wire [31:0]       wbDatR;
  wire              wbAck;
  wire              measStb;
  wire signed [15:0] peakPower;
  wire signed [15:0] totalPower;
  wire signed [15:0] rfPower;
  wire              carrierValid;
  wire [23:0]       carrierFreq;
  wire [7:0]        agcGain;
  wire [23:0]       tuneFreq;
  wire [12:0]       acqRangeKhz;
  wire [1:0]        tunerBwSel;
  wire [2:0]        videoBwSel;
  wire [7:0]        rfGainSet;
  wire [7:0]        ifGainSet;
  wire              carrierLock;
  wire              input_power_low_flag;
  wire              rfOverRange;
  wire              ifOverRange;
  wire signed [15:0] voutLevel;
  reg  [31:0]       rdData;
  reg  [15:0]       held;
  integer           badCount;
  integer           samplesChecked;
  integer           cycles;
  integer           i;
  blo_meas_model meas (.clk_sys, .carrierOn, .freqSet, .powerSet, .rfSet, .measStb,
    .peakPower, .totalPower, .rfPower, .carrierValid, .carrierFreq, .agcGain);
  blo_ctrl #(.SEC_CYC(SEC)) dut (.clk_sys, .rst_n, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .measStb, .peakPower, .totalPower, .rfPower,
    .carrierValid, .carrierFreq, .agcGain, .tuneFreq, .acqRangeKhz, .tunerBwSel,
    .videoBwSel, .rfGainSet, .ifGainSet, .carrierLock, .input_power_low_flag,
    .rfOverRange, .ifOverRange, .voutLevel);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task giveVerdict;
    begin
      $display("checks %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      badCount = badCount + 1;
      giveVerdict;
    end
  end
  task automatic wbAccess(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatW <= d;
      wbSel <= 4'hF;
      @(posedge clk_sys);
      while (wbAck !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (n == 20) badCount = badCount + 1;
      rdData = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      wbSel <= 4'h0;
      @(posedge clk_sys);
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (got !== exp) begin
        badCount = badCount + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wbAccess(a, 1'b1, d);
  endtask
  task rdChk(input [7:0] a, input [31:0] exp);
    begin
      wbAccess(a, 1'b0, 32'h0);
      check(rdData, exp);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    carrierOn = 1'b0;
    freqSet = 24'hF424F;
    powerSet = -16'sd500;
    rfSet = -16'sd400;
    badCount = 0;
    samplesChecked = 0;
    cycles = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdChk(`BLO_CTRL, 32'h24);
    rdChk(`BLO_REFLVL, 32'hFC18);
    rdChk(`BLO_VREF, 32'h0);
    rdChk(`BLO_VMAX, 32'h3E8);
    rdChk(`BLO_VMIN, 32'hFC18);
    rdChk(`BLO_SLOPE, 32'h07);
    rdChk(8'h3C, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`BLO_CTRL, i | 32'hDC);
      check(tunerBwSel, i);
    end
    wr(`BLO_CTRL, 32'hDF);
    check(tunerBwSel, 32'h2);
    for (i = 1; i < 8; i = i + 1) begin
      wr(`BLO_CTRL, (i << 2) | 32'h20);
      check(acqRangeKhz, ACQ[i]);
    end
    wr(`BLO_CTRL, 32'h20);
    check(acqRangeKhz, 32'd700);
    wr(`BLO_CTRL, 32'h95);
    check(acqRangeKhz, 32'd200);
    wr(`BLO_CTRL, 32'h8D);
    check(acqRangeKhz, 32'd200);
    wr(`BLO_CTRL, 32'h5D);
    rdChk(`BLO_CTRL, 32'h95);
    rdChk(`BLO_ALARM, 32'h4);
    wr(`BLO_ALARM, 32'h4);
    rdChk(`BLO_ALARM, 32'h0);
    for (i = 0; i < 7; i = i + 1) begin
      wr(`BLO_CTRL, (i << 9) | 32'h24);
      check(videoBwSel, i);
    end
    wr(`BLO_CTRL, 32'h24);
    wr(`BLO_REFLVL, 32'hFBB3);
    rdChk(`BLO_REFLVL, 32'hFC18);
    wr(`BLO_REFLVL, 32'hFF9C);
    rdChk(`BLO_REFLVL, 32'hFF9C);
    wr(`BLO_VMAX, 32'hFFFF);
    rdChk(`BLO_VMAX, 32'h3E8);
    wr(`BLO_VREF, 32'h3E9);
    rdChk(`BLO_VREF, 32'h0);
    wr(`BLO_ALARM, 32'h7);
    wr(`BLO_GAIN, 32'hC900);
    repeat (2) @(posedge clk_sys);
    check(rfOverRange, 32'h1);
    wr(`BLO_GAIN, 32'hC800);
    repeat (2) @(posedge clk_sys);
    check(rfOverRange, 32'h0);
    rdChk(`BLO_ALARM, 32'h1);
    check(ifGainSet, 32'h40);
    wr(`BLO_ALARM, 32'h1);
    wr(`BLO_CTRL, 32'h124);
    wr(`BLO_GAIN, 32'h9697);
    repeat (2) @(posedge clk_sys);
    check(ifGainSet, 32'h97);
    check(ifOverRange, 32'h1);
    rdChk(`BLO_ALARM, 32'h2);
    wr(`BLO_GAIN, 32'h0);
    wr(`BLO_CTRL, 32'h24);
    wr(`BLO_ALARM, 32'h7);
    rfSet <= -16'sd601;
    repeat (3) @(posedge clk_sys);
    check(input_power_low_flag, 32'h1);
    rfSet <= -16'sd600;
    repeat (3) @(posedge clk_sys);
    check(input_power_low_flag, 32'h0);
    wr(`BLO_CTRL, 32'h1C24);
    repeat (250) @(posedge clk_sys);
    rdChk(`BLO_DLVL, 32'hFFFFFE75);
    wr(`BLO_CTRL, 32'h3C24);
    rdChk(`BLO_REFLVL, 32'hFE11);
    powerSet <= -16'sd505;
    repeat (250) @(posedge clk_sys);
    // Carrier 15 kHz off lies outside the 10 kHz acquisition window
    wr(`BLO_FREQIN, 32'hF4240);
    wr(`BLO_SLOPE, 32'h17);
    check(tuneFreq, 32'hF4240);
    carrierOn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check(carrierLock, 32'h0);
    freqSet <= 24'hF4245;
    for (i = 0; i < 30 && carrierLock !== 1'b1; i = i + 1) @(posedge clk_sys);
    check(carrierLock, 32'h1);
    check({16'h0, voutLevel}, 32'hFF9C);
    rdChk(`BLO_DFREQ, 32'h5);
    freqSet <= 24'hF4259;
    for (i = 0; i < 30 && carrierLock !== 1'b0; i = i + 1) @(posedge clk_sys);
    check(carrierLock, 32'h0);
    held = voutLevel;
    repeat (3) @(posedge clk_sys);
    check({16'h0, voutLevel}, {16'h0, held});
    repeat (3 * SEC) @(posedge clk_sys);
    check({16'h0, voutLevel}, 32'hFC18);
    giveVerdict;
  end
endmodule
